// ---- verilog/sync_serial_port.sv ----
// What this block does
// R1: Shift one 8-bit word out and one in at once, on the serial clock.
// R2: As master, drive the serial clock pin and make every edge.
// R3: As slave, the serial clock pin is an input; the master makes all edges.
// R4: In slave mode a select input may gate transfers, when that option is on.
// R5: Configuration comes from control bits 5:0 and status bits 7:6.
// R6: Clock-rate choice applies only as master; slave follows the external clock.
// R7: The select option exists only for slave and is ignored as master.
// R8: A programmable polarity sets the idle level of the serial clock.
// R9: Control bit 4 is the clock polarity bit setting the idle level.
// R10: Status bit 6 picks whether data changes on the idle-to-active or the active-to-idle edge.
// R11: The transmit edge follows from polarity and edge select together.
// R12: Before slave enable the external clock must already rest at idle level.
// R13: As master, sample phase 1 samples at end, 0 in middle of output time.
// R14: Software keeps the sample phase bit clear in slave mode.
// R15: Software keeps sample phase and edge select clear in two-wire mode.
// R16: Two-wire slave: status bit 5 is 1 after data, 0 after address.
// R17: Two-wire: status bit 4 is 1 when a stop was seen last.
// R18: Two-wire: status bit 3 is 1 when a start was seen last, 0 at reset.
// R19: Status bit 0 shows the receive buffer holds a completed byte.
// R20: Status bit 2 holds direction from last address match until start, stop, ack.
// R21: Most significant bit first; at the end the byte is buffered and flagged.
// R22: Only status bits 7:6 are writable; the other six are read-only, reset zero.
module sync_serial_port
  import ssp_pkg::*;
#(
  parameter logic [7:0] TIMER_HALF = 8'h04
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire reg_req_t  req,
  output logic     [7:0] rdata,
  input  wire logic      sck_i,
  input  wire logic      sdi,
  input  wire logic      ss_n,
  output spi_pins_t      pins,
  input  wire i2c_evt_t  i2c_evt
);

  logic [5:0]  ctrl_ff;
  logic        smp_ff;
  logic        cke_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  tx_ff;
  logic [7:0]  nxt_tx;
  logic [7:0]  rx_ff;
  logic [7:0]  rx_next;
  logic [7:0]  buf_ff;
  logic        bf_ff;
  logic [3:0]  cnt_ff;
  logic        sampled_ff;
  logic        sck_prev_ff;
  logic        sck_ff;
  logic        sck_oe_n_ff;
  logic        sdo_ff;
  logic        sdo_oe_n_ff;
  logic        da_ff;
  logic        p_ff;
  logic        s_ff;
  logic        rw_ff;
  logic        ua_ff;
  mst_state_t  state_ff;
  mst_state_t  nxt_state;
  logic [7:0]  div_ff;
  logic [7:0]  nxt_div;
  logic [3:0]  hp_ff;
  logic [3:0]  nxt_hp;
  logic        sck_s;
  logic        sdi_s;
  logic        ss_n_s;
  logic        en;
  logic        clock_idle_polarity;
  logic [3:0]  mode;
  logic        is_master;
  logic        is_slave;
  logic        is_i2c;
  logic        ss_used;
  logic        slave_sel;
  logic        tick;
  logic        rise_act;
  logic        fall_idle;
  logic        m_smp;
  logic        m_tx;
  logic        smp_ev;
  logic        tx_ev;
  logic        done;
  logic        cnt_clr;
  logic        i2c_byte;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_buf;
  logic        rd_buf;
  logic [7:0]  stat_word;

  function automatic logic [7:0] half_len(input logic [3:0] m, input logic [7:0] tmr);
    logic [7:0] h;
    h = tmr;
    unique case (m)
      MODE_MASTER_DIV4:  h = HALF_DIV4;
      MODE_MASTER_DIV16: h = HALF_DIV16;
      MODE_MASTER_DIV64: h = HALF_DIV64;
      default:           h = tmr;
    endcase
    return h;
  endfunction : half_len

  pin_sync #(
    .W       (3),
    .RST_VAL (3'h1)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({sck_i, sdi, ss_n}),
    .q   ({sck_s, sdi_s, ss_n_s})
  );

  assign en        = ctrl_ff[CTRL_EN_BIT];                                          // R5
  assign clock_idle_polarity       = ctrl_ff[CTRL_CKP_BIT];                                         // R9
  assign mode      = ctrl_ff[3:0];                                                  // R5
  assign is_master = en && (mode <= MODE_MASTER_TMR);
  assign is_slave  = en && ((mode == MODE_SLAVE_SS) || (mode == MODE_SLAVE_NOSS));
  assign is_i2c    = en && (mode >= MODE_I2C_MIN);
  assign ss_used   = (mode == MODE_SLAVE_SS);                                       // R7
  assign slave_sel = is_slave && (!ss_used || !ss_n_s);                             // R4

  assign wr_ctrl = req.wr && (req.addr == CTRL_ADDR);
  assign wr_stat = req.wr && (req.addr == STAT_ADDR);
  assign wr_buf  = req.wr && (req.addr == BUF_ADDR);
  assign rd_buf  = req.rd && (req.addr == BUF_ADDR);

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= req.wdata[5:0];
    end
  end

  // Only the two phase bits of status take writes
  always_ff @(posedge clk) begin
    if (rst) begin
      {smp_ff, cke_ff} <= STAT_WR_RST;
    end else if (wr_stat) begin
      smp_ff <= req.wdata[STAT_SMP_BIT];                                            // R22
      cke_ff <= req.wdata[STAT_CKE_BIT];                                            // R22
    end
  end

  // Master bit clock; the rate is ignored unless master
  assign tick = (state_ff == M_RUN) && (div_ff == half_len(mode, TIMER_HALF) - 8'h01); // R6

  always_comb begin
    nxt_state = state_ff;
    nxt_div   = 8'h00;
    nxt_hp    = 4'h0;
    if (!is_master) begin
      nxt_state = M_IDLE;
    end else begin
      unique case (state_ff)
        M_IDLE: begin
          if (wr_buf) begin
            nxt_state = M_RUN;                                                      // R2
          end
        end
        M_RUN: begin
          nxt_div = tick ? 8'h00 : div_ff + 8'h01;
          nxt_hp  = tick ? hp_ff + 4'h1 : hp_ff;
          if (tick && (hp_ff == LAST_HALF)) begin
            nxt_state = M_IDLE;
            nxt_hp    = 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= M_IDLE;
      div_ff   <= 8'h00;
      hp_ff    <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      div_ff   <= nxt_div;
      hp_ff    <= nxt_hp;
    end
  end

  // Each bit owns two half periods; data moves at the start of the even one
  assign m_smp = tick && (smp_ff ? hp_ff[0] : !hp_ff[0]);                           // R13
  assign m_tx  = tick && hp_ff[0] && (hp_ff != LAST_HALF);

  // Slave edges seen on the synchronised clock, so slave rate is limited
  assign rise_act  = (sck_s != clock_idle_polarity) && (sck_prev_ff == clock_idle_polarity);
  assign fall_idle = (sck_s == clock_idle_polarity) && (sck_prev_ff != clock_idle_polarity);

  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_ff <= 1'b0;
    end else begin
      sck_prev_ff <= sck_s;                                                         // R3
    end
  end

  // Edge select meaning is relative to the idle level
  assign smp_ev = m_smp || (slave_sel && (cke_ff ? rise_act : fall_idle));          // R11
  assign tx_ev  = m_tx || (slave_sel && sampled_ff && (cke_ff ? fall_idle : rise_act)); // R10
  assign done   = smp_ev && (cnt_ff == LAST_BIT);                                   // R1
  assign cnt_clr = !(is_master || slave_sel) || ((state_ff == M_IDLE) && wr_buf && is_master);
  assign rx_next = {rx_ff[6:0], sdi_s};

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff     <= 4'h0;
      sampled_ff <= 1'b0;
    end else if (cnt_clr) begin
      cnt_ff     <= 4'h0;                                                           // R4
      sampled_ff <= 1'b0;
    end else begin
      if (smp_ev) begin
        cnt_ff <= done ? 4'h0 : cnt_ff + 4'h1;                                      // R1
      end
      if (smp_ev) begin
        sampled_ff <= 1'b1;
      end else if (tx_ev) begin
        sampled_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_ff <= BYTE_RST;
    end else if (smp_ev) begin
      rx_ff <= rx_next;                                                             // R21
    end
  end

  // A write during a master transfer is dropped; no collision is flagged anywhere
  always_comb begin
    nxt_tx = tx_ff;
    if (wr_buf && !(state_ff == M_RUN)) begin
      nxt_tx = req.wdata;
    end else if (tx_ev) begin
      nxt_tx = {tx_ff[6:0], 1'b0};                                                  // R21
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ff  <= BYTE_RST;
      sdo_ff <= 1'b0;
    end else begin
      tx_ff  <= nxt_tx;
      sdo_ff <= nxt_tx[7];                                                          // R1
    end
  end

  assign i2c_byte = is_i2c && (i2c_evt.addr_rcvd || i2c_evt.data_rcvd);

  // New byte beats a read in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_ff <= BYTE_RST;
      bf_ff  <= 1'b0;
    end else begin
      if (done) begin
        buf_ff <= rx_next;                                                          // R21
      end else if (i2c_byte) begin
        buf_ff <= i2c_evt.rx_byte;
      end
      if (done || i2c_byte) begin
        bf_ff <= 1'b1;                                                              // R19
      end else if (rd_buf) begin
        bf_ff <= 1'b0;
      end
    end
  end

  // Clock idles at the polarity bit; edge select shifts the phase
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_ff      <= 1'b0;
      sck_oe_n_ff <= 1'b1;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      sck_ff      <= (nxt_state == M_RUN) ? (clock_idle_polarity ^ nxt_hp[0] ^ ~cke_ff) : clock_idle_polarity;       // R8
      sck_oe_n_ff <= !is_master;                                                    // R2
      sdo_oe_n_ff <= !(is_master || slave_sel);                                     // R4
    end
  end

  // Two-wire status; address capture wins over clearing in the same cycle
  always_ff @(posedge clk) begin
    if (rst || !is_i2c) begin
      da_ff <= 1'b0;
      p_ff  <= 1'b0;
      s_ff  <= 1'b0;                                                                // R18
      rw_ff <= 1'b0;
      ua_ff <= 1'b0;
    end else begin
      ua_ff <= i2c_evt.upd_addr;
      if (i2c_evt.data_rcvd) begin
        da_ff <= 1'b1;                                                              // R16
      end else if (i2c_evt.addr_rcvd) begin
        da_ff <= 1'b0;                                                              // R16
      end
      if (i2c_evt.stop) begin
        p_ff <= 1'b1;                                                               // R17
        s_ff <= 1'b0;
      end else if (i2c_evt.start) begin
        s_ff <= 1'b1;                                                               // R18
        p_ff <= 1'b0;
      end
      if (i2c_evt.addr_rcvd) begin
        rw_ff <= i2c_evt.rw;                                                        // R20
      end else if (i2c_evt.start || i2c_evt.stop || i2c_evt.ack) begin
        rw_ff <= 1'b0;                                                              // R20
      end
    end
  end

  assign stat_word = {smp_ff, cke_ff, da_ff, p_ff, s_ff, rw_ff, ua_ff, bf_ff};     // R22

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        CTRL_ADDR: rdata_ff <= {2'h0, ctrl_ff};
        STAT_ADDR: rdata_ff <= stat_word;
        BUF_ADDR:  rdata_ff <= buf_ff;
        default:   rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata = rdata_ff;
  assign pins  = '{sck_o: sck_ff, sck_oe_n: sck_oe_n_ff, sdo: sdo_ff, sdo_oe_n: sdo_oe_n_ff};

  property p_master_drives;
    @(posedge clk) disable iff (rst) is_master |=> !sck_oe_n_ff;
  endproperty
  a_master_drives: assert property (p_master_drives) else $error("master not driving clock"); // R2

  property p_slave_input;
    @(posedge clk) disable iff (rst) is_slave |=> sck_oe_n_ff;
  endproperty
  a_slave_input: assert property (p_slave_input) else $error("slave drives clock"); // R3

  property p_idle_level;
    @(posedge clk) disable iff (rst)
      (state_ff == M_IDLE) && $stable(clock_idle_polarity) && $past(state_ff == M_IDLE) |-> sck_ff == clock_idle_polarity;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not at idle level"); // R8

  property p_tx_edge;
    @(posedge clk) disable iff (rst)
      (state_ff == M_RUN) && $past(state_ff == M_RUN) && $changed(hp_ff) && hp_ff[0] == 1'b0
      |-> sck_ff == (cke_ff ? clock_idle_polarity : !clock_idle_polarity);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("data moved on wrong clock edge"); // R10

  property p_deselect;
    @(posedge clk) disable iff (rst) is_slave && ss_used && ss_n_s |=> cnt_ff == 4'h0;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselected slave counted bits"); // R4

  property p_byte_done;
    @(posedge clk) disable iff (rst) done |=> bf_ff && (buf_ff == $past(rx_next));
  endproperty
  a_byte_done: assert property (p_byte_done) else $error("received byte not buffered"); // R21

  property p_slave_rate;
    @(posedge clk) disable iff (rst) !is_master |-> !tick ##1 (state_ff == M_IDLE);
  endproperty
  a_slave_rate: assert property (p_slave_rate) else $error("rate timer ran outside master"); // R6

  property p_stat_write;
    @(posedge clk) disable iff (rst)
      wr_stat ##1 req.rd && req.addr == STAT_ADDR && !wr_stat
      |=> rdata_ff[7:6] == $past(req.wdata[7:6], 2);
  endproperty
  a_stat_write: assert property (p_stat_write) else $error("phase bits not written"); // R22

  property p_start_seen;
    @(posedge clk) disable iff (rst)
      is_i2c && i2c_evt.start && !i2c_evt.stop ##1 is_i2c && !i2c_evt.stop |-> s_ff && !p_ff;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start flag wrong"); // R18

  property p_stop_seen;
    @(posedge clk) disable iff (rst) is_i2c && i2c_evt.stop ##1 is_i2c |-> p_ff && !s_ff;
  endproperty
  a_stop_seen: assert property (p_stop_seen) else $error("stop flag wrong"); // R17

  property p_data_addr;
    @(posedge clk) disable iff (rst) is_i2c && i2c_evt.addr_rcvd && !i2c_evt.data_rcvd
      ##1 is_i2c |-> !da_ff && bf_ff;
  endproperty
  a_data_addr: assert property (p_data_addr) else $error("address byte marked as data"); // R16

endmodule : sync_serial_port

// ---- verilog/ssp_pkg.sv ----
package ssp_pkg;

  // Register addresses on the plain register port
  localparam logic [1:0] CTRL_ADDR = 2'h0;
  localparam logic [1:0] STAT_ADDR = 2'h1;
  localparam logic [1:0] BUF_ADDR  = 2'h2;

  // Control register fields
  localparam int CTRL_EN_BIT  = 5;
  localparam int CTRL_CKP_BIT = 4;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // Status register fields
  localparam int STAT_SMP_BIT = 7;
  localparam int STAT_CKE_BIT = 6;
  localparam int STAT_DA_BIT  = 5;
  localparam int STAT_P_BIT   = 4;
  localparam int STAT_S_BIT   = 3;
  localparam int STAT_RW_BIT  = 2;
  localparam int STAT_UA_BIT  = 1;
  localparam int STAT_BF_BIT  = 0;
  localparam logic [1:0] STAT_WR_RST = 2'h0;

  // Port mode codes in the control register low nibble
  localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TMR   = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SS     = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSS   = 4'h5;
  localparam logic [3:0] MODE_I2C_MIN      = 4'h6;

  // Serial clock half periods in system clock cycles
  // Fastest rate still leaves room for the two-flop delay on the data input
  localparam logic [7:0] HALF_DIV4  = 8'h04;
  localparam logic [7:0] HALF_DIV16 = 8'h08;
  localparam logic [7:0] HALF_DIV64 = 8'h20;

  localparam logic [3:0] LAST_HALF = 4'hF;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_RUN  = 1'b1
  } mst_state_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
  } spi_pins_t;

  // Pulses and levels from the two-wire protocol engine
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       addr_rcvd;
    logic       data_rcvd;
    logic       ack;
    logic       rw;
    logic       upd_addr;
    logic [7:0] rx_byte;
  } i2c_evt_t;

endpackage : ssp_pkg

// ---- verilog/pin_sync.sv ----
module pin_sync
  import ssp_pkg::*;
#(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : pin_sync

// ---- tb/spi_far_end.sv ----
module spi_far_end (
  input  wire logic clk,
  input  wire logic sck_o,
  input  wire logic sdo,
  input  wire logic clock_idle_polarity,
  input  wire logic cke,
  output logic      sck_m,
  output logic      sdi,
  output logic      ss_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_sr = 8'h00;
  logic [7:0] rx_sr = 8'h00;
  logic       active = 1'b0;
  logic       drive = 1'b0;
  logic       late = 1'b0;
  logic       sel = 1'b0;
  int         n_odd = 0;
  initial sdi = 1'b0;
  initial sck_m = 1'b0;
  assign ss_n = ~sel;
  always @(clock_idle_polarity) if (!drive) sck_m = clock_idle_polarity;
  // A released data line keeps changing so a stale bit never looks valid
  always @(posedge clk) if (!active) sdi <= ~sdi;
  always @(tx_sr, active) if (active && !drive) sdi = tx_sr[7];
  // Reacts at once to the clock pin, as a real slave would
  always @(sck_o) if (active && !drive) begin
    if (sck_o == (clock_idle_polarity ^ cke)) begin
      rx_sr = {rx_sr[6:0], sdo};
      n_odd++;
      if (late && n_odd > 1) tx_sr = tx_sr << 1;
    end else if (!late && n_odd > 0) tx_sr = tx_sr << 1;
  end
  task automatic arm(input logic [7:0] b, input logic lt);
    n_odd = 0;
    late = lt;
    tx_sr = b;
    active = 1'b1;
  endtask : arm
  task automatic done;
    active = 1'b0;
  endtask : done
  task automatic clock_byte(input logic [7:0] b, input int half);
    drive = 1'b1;
    active = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      // Data moves on the transmit edge, never beside the sampling edge
      if (cke) sdi = b[i];
      repeat (half) @(posedge clk);
      #3 if (cke) rx_sr = {rx_sr[6:0], sdo};
      sck_m = ~clock_idle_polarity;
      if (!cke) sdi = b[i];
      repeat (half) @(posedge clk);
      #3 if (!cke) rx_sr = {rx_sr[6:0], sdo};
      sck_m = clock_idle_polarity;
    end
    repeat (half) @(posedge clk);
    active = 1'b0;
    drive = 1'b0;
  endtask : clock_byte
endmodule : spi_far_end

// ---- tb/sync_serial_port_tb.sv ----
module sync_serial_port_tb;
  import ssp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] TH = 8'h03;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  reg_req_t   req;
  logic [7:0] rdata;
  spi_pins_t  pins;
  i2c_evt_t   ev;
  logic       sck_i;
  logic       sck_m;
  logic       sdi;
  logic       ss_n;
  logic       clock_idle_polarity = 1'b0;
  logic       cke = 1'b0;
  logic       input_sample_phase = 1'b0;
  logic       prev_sck = 1'b0;
  logic [7:0] b;
  logic [7:0] p;
  logic [7:0] st_exp [6] = '{8'h08, 8'h0D, 8'h2D, 8'h29, 8'h31, 8'h33};
  logic [6:0] ev_flag [6] = '{7'h40, 7'h12, 7'h08, 7'h04, 7'h20, 7'h01};
  logic [7:0] ev_byte [6] = '{8'h00, 8'hA5, 8'h3C, 8'h00, 8'h00, 8'h00};
  integer     seed = 32'h9b474442;
  int         failures = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         edges = 0;
  int         gap_err = 0;
  int         last_t = 0;
  int         half = 2;
  int         ok;

  // The clock pin is two-way: whoever enables it sets the level
  assign sck_i = pins.sck_oe_n ? sck_m : pins.sck_o;
  always #12.5 clk = ~clk;

  sync_serial_port #(.TIMER_HALF(TH)) i_sync_serial_port (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .sck_i(sck_i), .sdi(sdi), .ss_n(ss_n), .pins(pins), .i2c_evt(ev));
  spi_far_end far (.clk(clk), .sck_o(pins.sck_o), .sdo(pins.sdo), .clock_idle_polarity(clock_idle_polarity), .cke(cke),
    .sck_m(sck_m), .sdi(sdi), .ss_n(ss_n));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_sck <= pins.sck_o;
    if (pins.sck_o !== prev_sck) begin
      if (edges > 0 && cyc - last_t != half) gap_err++;
      edges++;
      last_t = cyc;
    end
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [1:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 if (nm != "") chk(nm, rdata, exp);
  endtask : rc

  // Waits on the buffer-full flag; the read count bounds a hang
  task automatic wait_bf;
    for (int k = 0; k < 300; k++) begin
      rc(STAT_ADDR, 8'h00, "");
      if (rdata[0] === 1'b1) break;
    end
  endtask : wait_bf

  // Disabled while polarity moves, so no stray clock edge is seen
  task automatic cfg(input logic [3:0] m, input logic k_p, input logic k_e, input logic s_p);
    wr(CTRL_ADDR, 8'h00);
    clock_idle_polarity = k_p;
    cke = k_e;
    input_sample_phase = s_p;
    wr(STAT_ADDR, {input_sample_phase, cke, 6'h00});
    repeat (4) @(posedge clk);
    wr(CTRL_ADDR, {2'b00, 1'b1, clock_idle_polarity, m});
    repeat (4) @(posedge clk);
  endtask : cfg

  initial begin
    req = '0;
    ev = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rc(CTRL_ADDR, 8'h00, "ctrl reset");
    rc(STAT_ADDR, 8'h00, "stat reset");
    wr(STAT_ADDR, 8'hFF);
    rc(STAT_ADDR, 8'hC0, "stat write");
    wr(CTRL_ADDR, 8'hFF);
    rc(CTRL_ADDR, 8'h3F, "ctrl write");
    wr(2'h3, 8'h5A);
    rc(2'h3, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      half = (i % 4 == 0) ? 4 : (i % 4 == 1) ? 8 : (i % 4 == 2) ? 32 : int'(TH);
      cfg(4'(i % 4), i[2], i[0] ^ i[2], i[1]);
      chk("sck idle", 8'(pins.sck_o), 8'(clock_idle_polarity));
      chk("sck drive", 8'({pins.sck_oe_n, pins.sdo_oe_n}), 8'h00);
      b = 8'($random(seed));
      p = 8'($random(seed));
      far.arm(p, input_sample_phase);
      edges = 0;
      gap_err = 0;
      wr(BUF_ADDR, b);
      wait_bf();
      repeat (2 * half + 4) @(posedge clk);
      chk("sck edges", 8'(edges), 8'h10);
      chk("half period", 8'(gap_err), 8'h00);
      chk("sent byte", far.rx_sr, b);
      rc(BUF_ADDR, p, "master rx");
      rc(STAT_ADDR, {input_sample_phase, cke, 6'h00}, "bf clear");
      far.done();
    end
    for (int i = 0; i < 4; i++) begin
      ok = i[0] | i[1];
      far.sel = i[0];
      cfg(i[1] ? MODE_SLAVE_NOSS : MODE_SLAVE_SS, i[0] ^ i[1], i[0], 1'b0);
      b = 8'($random(seed));
      p = 8'($random(seed));
      wr(BUF_ADDR, b);
      repeat (4) @(posedge clk);
      chk("sck input", 8'(pins.sck_oe_n), 8'h01);
      chk("sdo gate", 8'(pins.sdo_oe_n), 8'(!ok));
      far.clock_byte(p, 6);
      repeat (6) @(posedge clk);
      rc(STAT_ADDR, {1'b0, cke, 5'h00, 1'(ok)}, "slave bf");
      if (ok) begin
        rc(BUF_ADDR, p, "slave rx");
        chk("slave tx", far.rx_sr, b);
      end
    end
    far.sel = 1'b0;
    cfg(MODE_I2C_MIN, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      ev <= {ev_flag[i], ev_byte[i]};
      @(posedge clk);
      ev <= {5'h00, ev_flag[i][1:0], ev_byte[i]};
      rc(STAT_ADDR, st_exp[i], "two-wire status");
    end
    rc(BUF_ADDR, 8'h3C, "two-wire rx");
    rc(STAT_ADDR, 8'h32, "two-wire bf");
    stop_test();
  end
endmodule : sync_serial_port_tb
